// File: core/wbc_pkg.sv
package wbc_pkg;

    // ====================
    // register addresses on the 7-bit serial address field
    // ====================
    localparam logic [6:0] WBC_ADDR_WDOG_CONFIG = 7'h03;
    localparam logic [6:0] WBC_ADDR_BUS_CTRL_A  = 7'h04;
    localparam logic [6:0] WBC_ADDR_BUS_CTRL_B  = 7'h05;

    // ====================
    // serial frame layout (lsb first)
    // ====================
    localparam int unsigned WBC_FRAME_BITS  = 16;
    localparam int unsigned WBC_ADDR_LSB    = 0;
    localparam int unsigned WBC_WRITE_BIT   = 7;
    localparam int unsigned WBC_DATA_LSB    = 8;
    localparam logic [4:0]  WBC_CNT_ADDR_OK = 5'h08;
    localparam logic [4:0]  WBC_CNT_FULL    = 5'h10;

    // ====================
    // watchdog configuration fields
    // ====================
    localparam int unsigned WBC_WD_CHECKSUM_BIT = 7;
    localparam int unsigned WBC_WD_STOP_DIS_BIT = 6;
    localparam int unsigned WBC_WD_WINDOW_BIT   = 5;
    localparam int unsigned WBC_WD_BUS_WAKE_BIT = 4;
    localparam int unsigned WBC_WD_PERIOD_LSB   = 0;
    localparam logic [7:0]  WBC_WD_WRITE_MASK   = 8'hF7;
    localparam logic [2:0]  WBC_WD_PERIOD_FIRST_RSVD = 3'h6;
    localparam logic [7:0]  WBC_WD_RESET        = 8'h14;
    localparam logic [3:0]  WBC_WD_RESTART_LO   = 4'h4;

    // ====================
    // bus control a / b fields
    // ====================
    localparam int unsigned WBC_BA_FLASH_BIT    = 7;
    localparam int unsigned WBC_BA_LOW_SLOPE_BIT = 6;
    localparam int unsigned WBC_BA_TX_TO_BIT    = 5;
    localparam int unsigned WBC_BA_LIN_LSB      = 3;
    localparam int unsigned WBC_BA_CAN_LSB      = 0;
    localparam logic [7:0]  WBC_BA_WRITE_MASK   = 8'hFB;
    localparam logic [7:0]  WBC_BA_RESET        = 8'h20;
    localparam int unsigned WBC_BB_PEAK_BIT     = 5;
    localparam int unsigned WBC_BB_LIN_LSB      = 0;
    localparam logic [7:0]  WBC_BB_WRITE_MASK   = 8'h23;
    localparam logic [7:0]  WBC_BB_RESET        = 8'h00;

    // ====================
    // transceiver modes and fail-safe wake values
    // ====================
    typedef enum logic [1:0] {
        WBC_TRX_OFF       = 2'h0,
        WBC_TRX_WAKE      = 2'h1,
        WBC_TRX_RX_ONLY   = 2'h2,
        WBC_TRX_NORMAL    = 2'h3
    } wbc_trx_mode_t;

    localparam logic [1:0] WBC_FS_TRX_MODE = 2'h1;

    // system mode reported by the mode controller
    typedef enum logic [2:0] {
        WBC_SBC_INIT      = 3'h0,
        WBC_SBC_NORMAL    = 3'h1,
        WBC_SBC_STOP      = 3'h2,
        WBC_SBC_SLEEP     = 3'h3,
        WBC_SBC_RESTART   = 3'h4,
        WBC_SBC_FAILSAFE  = 3'h5
    } wbc_sbc_mode_t;

endpackage : wbc_pkg

// File: core/wbc_serial_frame.sv
`timescale 1ns/1ps
`default_nettype none

module wbc_serial_frame
    import wbc_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_sclk,
    input  wire logic       i_mosi,
    input  wire logic       i_chip_select_n,
    input  wire logic [7:0] i_status,
    input  wire logic [7:0] i_rd_data,
    output logic            o_miso,
    output logic            o_miso_oe,
    output logic [6:0]      o_addr,
    output logic            o_write,
    output logic [7:0]      o_wdata,
    output logic            o_frame_done,
    output logic            o_frame_bad
);

    // ====================
    // pin synchronisers
    // ====================
    logic [2:0]  sclk_sync_reg;
    logic [1:0]  mosi_sync_reg;
    logic [2:0]  csn_sync_reg;
    logic [15:0] rx_reg;
    logic [7:0]  tx_reg;
    logic [4:0]  bit_cnt_reg;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_fall;
    logic        cs_rise;
    logic        in_frame;

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sclk_sync_reg <= 3'h0;
            mosi_sync_reg <= 2'h0;
            csn_sync_reg  <= 3'h7;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], i_sclk};
            mosi_sync_reg <= {mosi_sync_reg[0], i_mosi};
            csn_sync_reg  <= {csn_sync_reg[1:0], i_chip_select_n};
        end
    end

    // edges look only at stages 1 and 2, never the first flop
    assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
    assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
    assign cs_fall   = ~csn_sync_reg[1] & csn_sync_reg[2];
    assign cs_rise   = csn_sync_reg[1] & ~csn_sync_reg[2];
    assign in_frame  = ~csn_sync_reg[1];

    // ====================
    // receive: sample on rising clock edge
    // ====================
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rx_reg      <= 16'h0000;
            bit_cnt_reg <= 5'h00;
        end else if (cs_fall) begin
            rx_reg      <= 16'h0000;
            bit_cnt_reg <= 5'h00;
        end else if (in_frame && sclk_rise) begin
            if (bit_cnt_reg < WBC_CNT_FULL) begin
                rx_reg[bit_cnt_reg[3:0]] <= mosi_sync_reg[1];
            end
            // saturate one past full so long frames are seen as bad
            if (bit_cnt_reg <= WBC_CNT_FULL) begin
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
        end
    end

    // ====================
    // transmit: status first, then the stored register byte
    // ====================
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tx_reg <= 8'h00;
        end else if (cs_fall) begin
            tx_reg <= i_status;
        end else if (in_frame && sclk_fall) begin
            if (bit_cnt_reg == WBC_CNT_ADDR_OK) begin
                tx_reg <= i_rd_data; // RL22
            end else begin
                tx_reg <= {1'b0, tx_reg[7:1]};
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_frame_done <= 1'b0;
            o_frame_bad  <= 1'b0;
        end else begin
            o_frame_done <= cs_rise && (bit_cnt_reg == WBC_CNT_FULL);
            o_frame_bad  <= cs_rise && (bit_cnt_reg != WBC_CNT_FULL);
        end
    end

    assign o_miso    = tx_reg[0];
    assign o_miso_oe = in_frame;
    assign o_addr    = rx_reg[WBC_ADDR_LSB +: 7];
    assign o_write   = rx_reg[WBC_WRITE_BIT];
    assign o_wdata   = rx_reg[WBC_DATA_LSB +: 8];

endmodule : wbc_serial_frame

`default_nettype wire

// File: core/wbc_regs.sv
// What this block does
// RL1 - host sets checksum bit so the written watchdog byte has even parity
// RL2 - watchdog bit 6 set deactivates the watchdog in stop mode
// RL3 - watchdog bit 5 selects time-out (0) or window (1) supervision
// RL4 - watchdog bit 4 starts watchdog with long open window after bus wake
// RL5 - every reserved bit reads back as zero
// RL6 - period field codes 000..101 give 10..500 ms; 110 and 111 reserved
// RL7 - power-on and soft reset load watchdog register with 0x14
// RL8 - restart clears bit 6, loads 0100 low, keeps bits 7, 5, 4
// RL9 - bus a bit 7 enables flash mode, slope control off up to 115 kBaud
// RL10 - bus a bit 6 selects LIN low-slope mode at 10.4 kBaud
// RL11 - bus a bit 5 enables LIN transmit-data time-out
// RL12 - bus a bits 4:3 set first LIN transceiver mode
// RL13 - bus a bits 1:0 set CAN transceiver mode
// RL14 - bus b bits 1:0 set second LIN transceiver mode
// RL15 - LIN slope and time-out bits act at chip select high, both LINs
// RL16 - fail-safe entry forces wake values in bus a, bus b, external wake
// RL17 - bus b bit 5 selects the higher VCC1 peak threshold
// RL18 - peak bit writable in init and normal only; stop writes silently ignored
// RL19 - power-on and soft reset load bus a with 0x20
// RL20 - bus b resets to zero; restart keeps bit 5, LIN mode by cause
// RL21 - transceiver mode reload values depend on the cause of change
// RL22 - serial output shows previous register contents during a write
// RL23 - reserved bits ignore writes; period codes 110 and 111 ignored
// RL24 - host writes touch writable fields; hardware may update mode fields
`timescale 1ns/1ps
`default_nettype none

module wbc_regs
    import wbc_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_sclk,
    input  wire logic       i_mosi,
    input  wire logic       i_chip_select_n,
    output logic            o_miso,
    output logic            o_miso_oe,
    input  wire logic [7:0] i_status,
    input  wire logic [2:0] i_sbc_mode,
    input  wire logic       i_soft_reset,
    input  wire logic       i_restart,
    input  wire logic       i_failsafe_entry,
    input  wire logic       i_trx_update,
    input  wire logic [1:0] i_cause_can_mode,
    input  wire logic [1:0] i_cause_lin_a_mode,
    input  wire logic [1:0] i_cause_lin_b_mode,
    output logic            o_wdog_stop_disable_lo,
    output logic            o_wdog_window_select,
    output logic            o_wdog_start_on_bus_wake,
    output logic [2:0]      o_wdog_period_sel,
    output logic [9:0]      o_wdog_period_ms,
    output logic            o_wdog_checksum_ok,
    output logic            o_lin_flash_en,
    output logic            o_lin_low_slope_sel,
    output logic            o_lin_tx_timeout_en,
    output logic [1:0]      o_lin_a_mode,
    output logic [1:0]      o_lin_b_mode,
    output logic [1:0]      o_can_mode,
    output logic            o_peak_current_thresh_sel,
    output logic            o_external_wake_reg_force,
    output logic            o_spi_fail
);

    // ====================
    // serial frame engine
    // ====================
    logic [6:0] frm_addr;
    logic       frm_write;
    logic [7:0] frm_wdata;
    logic       frm_done;
    logic       frm_bad;
    logic [7:0] rd_data;

    logic [7:0] wdog_config_reg;
    logic [7:0] bus_ctrl_a_reg;
    logic [7:0] bus_ctrl_b_reg;

    wbc_serial_frame u_frame (
        .i_mclk          (i_mclk),
        .i_sys_rst       (i_sys_rst),
        .i_sclk          (i_sclk),
        .i_mosi          (i_mosi),
        .i_chip_select_n (i_chip_select_n),
        .i_status        (i_status),
        .i_rd_data       (rd_data),
        .o_miso          (o_miso),
        .o_miso_oe       (o_miso_oe),
        .o_addr          (frm_addr),
        .o_write         (frm_write),
        .o_wdata         (frm_wdata),
        .o_frame_done    (frm_done),
        .o_frame_bad     (frm_bad)
    );

    // ====================
    // read mux: stored values only, reserved bits held at zero
    // ====================
    always_comb begin
        unique case (frm_addr)
            WBC_ADDR_WDOG_CONFIG: rd_data = wdog_config_reg & WBC_WD_WRITE_MASK; // RL5
            WBC_ADDR_BUS_CTRL_A:  rd_data = bus_ctrl_a_reg & WBC_BA_WRITE_MASK; // RL5
            WBC_ADDR_BUS_CTRL_B:  rd_data = bus_ctrl_b_reg & WBC_BB_WRITE_MASK; // RL5
            default:              rd_data = 8'h00;
        endcase
    end

    // ====================
    // write qualification
    // ====================
    logic wr_any;
    logic wr_wdog;
    logic wr_bus_a;
    logic wr_bus_b;
    logic parity_ok;
    logic period_legal;
    logic peak_writable;
    logic hw_event;

    assign wr_any       = frm_done & frm_write;
    // a write racing a hardware reload loses; the reload reflects device state
    assign hw_event     = i_soft_reset | i_failsafe_entry | i_restart | i_trx_update;
    assign parity_ok    = ~(^frm_wdata);
    assign period_legal = frm_wdata[WBC_WD_PERIOD_LSB +: 3] < WBC_WD_PERIOD_FIRST_RSVD; // RL23
    assign peak_writable = (i_sbc_mode == WBC_SBC_INIT) || (i_sbc_mode == WBC_SBC_NORMAL); // RL18
    assign wr_wdog  = wr_any && (frm_addr == WBC_ADDR_WDOG_CONFIG) && parity_ok;
    assign wr_bus_a = wr_any && (frm_addr == WBC_ADDR_BUS_CTRL_A);
    assign wr_bus_b = wr_any && (frm_addr == WBC_ADDR_BUS_CTRL_B);

    // ====================
    // watchdog configuration
    // ====================
    logic [7:0] wdog_config_next;

    always_comb begin
        wdog_config_next = wdog_config_reg;
        if (i_soft_reset) begin
            wdog_config_next = WBC_WD_RESET; // RL7
        end else if (i_restart) begin
            wdog_config_next[WBC_WD_STOP_DIS_BIT] = 1'b0; // RL8
            wdog_config_next[3:0] = WBC_WD_RESTART_LO; // RL8
        end else if (wr_wdog) begin
            wdog_config_next[WBC_WD_CHECKSUM_BIT] = frm_wdata[WBC_WD_CHECKSUM_BIT]; // RL1
            wdog_config_next[WBC_WD_STOP_DIS_BIT] = frm_wdata[WBC_WD_STOP_DIS_BIT]; // RL2
            wdog_config_next[WBC_WD_WINDOW_BIT]   = frm_wdata[WBC_WD_WINDOW_BIT]; // RL3
            wdog_config_next[WBC_WD_BUS_WAKE_BIT] = frm_wdata[WBC_WD_BUS_WAKE_BIT]; // RL4
            if (period_legal) begin
                wdog_config_next[WBC_WD_PERIOD_LSB +: 3] = frm_wdata[WBC_WD_PERIOD_LSB +: 3]; // RL6
            end
        end
        wdog_config_next = wdog_config_next & WBC_WD_WRITE_MASK; // RL23
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wdog_config_reg <= WBC_WD_RESET; // RL7
        end else begin
            wdog_config_reg <= wdog_config_next;
        end
    end

    // ====================
    // bus transceiver control a
    // ====================
    logic [7:0] bus_ctrl_a_next;

    always_comb begin
        bus_ctrl_a_next = bus_ctrl_a_reg;
        if (i_soft_reset) begin
            bus_ctrl_a_next = WBC_BA_RESET; // RL19
        end else if (i_failsafe_entry) begin
            bus_ctrl_a_next[WBC_BA_LIN_LSB +: 2] = WBC_FS_TRX_MODE; // RL16
            bus_ctrl_a_next[WBC_BA_CAN_LSB +: 2] = WBC_FS_TRX_MODE; // RL16
        end else if (i_restart || i_trx_update) begin
            bus_ctrl_a_next[WBC_BA_LIN_LSB +: 2] = i_cause_lin_a_mode; // RL21
            bus_ctrl_a_next[WBC_BA_CAN_LSB +: 2] = i_cause_can_mode; // RL21
        end else if (wr_bus_a) begin
            bus_ctrl_a_next = frm_wdata & WBC_BA_WRITE_MASK; // RL24
        end
        bus_ctrl_a_next = bus_ctrl_a_next & WBC_BA_WRITE_MASK; // RL23
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            bus_ctrl_a_reg <= WBC_BA_RESET; // RL19
        end else begin
            bus_ctrl_a_reg <= bus_ctrl_a_next;
        end
    end

    // ====================
    // bus transceiver control b
    // ====================
    logic [7:0] bus_ctrl_b_next;

    always_comb begin
        bus_ctrl_b_next = bus_ctrl_b_reg;
        if (i_soft_reset) begin
            bus_ctrl_b_next = WBC_BB_RESET; // RL20
        end else if (i_failsafe_entry) begin
            bus_ctrl_b_next = {6'h00, WBC_FS_TRX_MODE}; // RL16
        end else if (i_restart || i_trx_update) begin
            // peak bit survives restart, everything else but LIN mode clears
            bus_ctrl_b_next = bus_ctrl_b_reg & (8'h01 << WBC_BB_PEAK_BIT); // RL20
            bus_ctrl_b_next[WBC_BB_LIN_LSB +: 2] = i_cause_lin_b_mode; // RL21
        end else if (wr_bus_b) begin
            bus_ctrl_b_next[WBC_BB_LIN_LSB +: 2] = frm_wdata[WBC_BB_LIN_LSB +: 2]; // RL14
            if (peak_writable) begin
                bus_ctrl_b_next[WBC_BB_PEAK_BIT] = frm_wdata[WBC_BB_PEAK_BIT]; // RL18
            end
        end
        bus_ctrl_b_next = bus_ctrl_b_next & WBC_BB_WRITE_MASK; // RL23
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            bus_ctrl_b_reg <= WBC_BB_RESET; // RL20
        end else begin
            bus_ctrl_b_reg <= bus_ctrl_b_next;
        end
    end

    // ====================
    // error flag and fail-safe side effect
    // ====================
    // bad frame length or a watchdog byte with odd parity; a stop-mode
    // write to the peak bit is deliberately not reported
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_spi_fail                <= 1'b0;
            o_external_wake_reg_force <= 1'b0;
        end else begin
            o_spi_fail <= frm_bad ||
                          (wr_any && (frm_addr == WBC_ADDR_WDOG_CONFIG) && !parity_ok); // RL18
            o_external_wake_reg_force <= i_failsafe_entry; // RL16
        end
    end

    // ====================
    // decoded outputs
    // ====================
    // all fields come straight from the registers, which only change on
    // frame end (chip select high) or on a hardware event
    assign o_wdog_stop_disable_lo   = wdog_config_reg[WBC_WD_STOP_DIS_BIT]; // RL2
    assign o_wdog_window_select     = wdog_config_reg[WBC_WD_WINDOW_BIT]; // RL3
    assign o_wdog_start_on_bus_wake = wdog_config_reg[WBC_WD_BUS_WAKE_BIT]; // RL4
    assign o_wdog_period_sel        = wdog_config_reg[WBC_WD_PERIOD_LSB +: 3];
    assign o_wdog_checksum_ok       = ~(^wdog_config_reg);
    assign o_lin_flash_en           = bus_ctrl_a_reg[WBC_BA_FLASH_BIT]; // RL9
    assign o_lin_low_slope_sel      = bus_ctrl_a_reg[WBC_BA_LOW_SLOPE_BIT]; // RL10
    assign o_lin_tx_timeout_en      = bus_ctrl_a_reg[WBC_BA_TX_TO_BIT]; // RL11
    assign o_lin_a_mode             = bus_ctrl_a_reg[WBC_BA_LIN_LSB +: 2]; // RL12
    assign o_can_mode               = bus_ctrl_a_reg[WBC_BA_CAN_LSB +: 2]; // RL13
    assign o_lin_b_mode             = bus_ctrl_b_reg[WBC_BB_LIN_LSB +: 2]; // RL14
    assign o_peak_current_thresh_sel = bus_ctrl_b_reg[WBC_BB_PEAK_BIT]; // RL17
    // slope and time-out bits are shared by both LIN transceivers RL15

    always_comb begin
        unique case (o_wdog_period_sel)
            3'h0:    o_wdog_period_ms = 10'd10; // RL6
            3'h1:    o_wdog_period_ms = 10'd20;
            3'h2:    o_wdog_period_ms = 10'd50;
            3'h3:    o_wdog_period_ms = 10'd100;
            3'h4:    o_wdog_period_ms = 10'd200;
            3'h5:    o_wdog_period_ms = 10'd500;
            default: o_wdog_period_ms = 10'd0;
        endcase
    end

endmodule : wbc_regs

`default_nettype wire

// File: sim/wbc_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none

module wbc_regs_properties
    import wbc_pkg::*;
(
    input wire logic       i_mclk,
    input wire logic       i_sys_rst,
    input wire logic       i_chip_select_n,
    input wire logic [2:0] i_sbc_mode,
    input wire logic       i_soft_reset,
    input wire logic       i_restart,
    input wire logic       i_failsafe_entry,
    input wire logic       i_trx_update,
    input wire logic [1:0] i_cause_can_mode,
    input wire logic [1:0] i_cause_lin_a_mode,
    input wire logic [1:0] i_cause_lin_b_mode,
    input wire logic       o_wdog_stop_disable_lo,
    input wire logic       o_wdog_window_select,
    input wire logic       o_wdog_start_on_bus_wake,
    input wire logic [2:0] o_wdog_period_sel,
    input wire logic [9:0] o_wdog_period_ms,
    input wire logic       o_lin_tx_timeout_en,
    input wire logic [1:0] o_lin_a_mode,
    input wire logic [1:0] o_lin_b_mode,
    input wire logic [1:0] o_can_mode,
    input wire logic       o_peak_current_thresh_sel,
    input wire logic       o_external_wake_reg_force
);
    // ==========================================
    // sequences
    // ==========================================
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    localparam logic [9:0] ms_tab [8] = '{10'h00A, 10'h014, 10'h032, 10'h064, 10'h0C8, 10'h1F4, 10'h000, 10'h000};

    sequence fs_s;
        i_failsafe_entry && !i_soft_reset;
    endsequence
    // quiet long enough that any frame commit has already landed
    sequence quiet_s;
        (i_chip_select_n && !i_soft_reset && !i_restart && !i_failsafe_entry && !i_trx_update) [*8];
    endsequence

    // ==========================================
    // assertions
    // ==========================================
    fs_force_a: assert property (fs_s |=> o_external_wake_reg_force)
        else $error("wake register force pulse missing");
    fs_values_a: assert property (fs_s |=> o_lin_a_mode == 2'h1 && o_can_mode == 2'h1 && o_lin_b_mode == 2'h1
        && !o_peak_current_thresh_sel && o_lin_tx_timeout_en == $past(o_lin_tx_timeout_en))
        else $error("fail-safe values wrong");
    soft_rst_a: assert property (i_soft_reset |=> o_wdog_period_sel == 3'h4 && o_wdog_start_on_bus_wake
        && !o_wdog_window_select && o_lin_tx_timeout_en && o_can_mode == 2'h0 && o_lin_b_mode == 2'h0)
        else $error("soft reset values wrong");
    restart_a: assert property (i_restart && !i_soft_reset && !i_failsafe_entry |=> !o_wdog_stop_disable_lo
        && o_wdog_period_sel == 3'h4 && o_wdog_window_select == $past(o_wdog_window_select)
        && o_lin_b_mode == $past(i_cause_lin_b_mode) && o_peak_current_thresh_sel == $past(o_peak_current_thresh_sel))
        else $error("restart values wrong");
    trx_upd_a: assert property (i_trx_update && !i_soft_reset && !i_failsafe_entry
        |=> o_can_mode == $past(i_cause_can_mode) && o_lin_a_mode == $past(i_cause_lin_a_mode))
        else $error("transceiver reload wrong");
    period_ms_a: assert property (o_wdog_period_ms == ms_tab[o_wdog_period_sel])
        else $error("period decode wrong");
    period_legal_a: assert property (o_wdog_period_sel < 3'h6)
        else $error("reserved period stored");
    quiet_hold_a: assert property (quiet_s |=> $stable({o_wdog_period_sel, o_wdog_window_select, o_can_mode,
        o_lin_a_mode, o_lin_b_mode, o_lin_tx_timeout_en, o_peak_current_thresh_sel}))
        else $error("field changed without cause");
    stop_peak_a: assert property (i_sbc_mode == WBC_SBC_STOP && !i_soft_reset && !i_failsafe_entry
        |=> $stable(o_peak_current_thresh_sel))
        else $error("peak bit changed in stop");
endmodule : wbc_regs_properties

bind wbc_regs wbc_regs_properties i_wbc_regs_properties (.i_mclk, .i_sys_rst, .i_chip_select_n, .i_sbc_mode,
    .i_soft_reset, .i_restart, .i_failsafe_entry, .i_trx_update, .i_cause_can_mode, .i_cause_lin_a_mode,
    .i_cause_lin_b_mode, .o_wdog_stop_disable_lo, .o_wdog_window_select, .o_wdog_start_on_bus_wake,
    .o_wdog_period_sel, .o_wdog_period_ms, .o_lin_tx_timeout_en, .o_lin_a_mode, .o_lin_b_mode, .o_can_mode,
    .o_peak_current_thresh_sel, .o_external_wake_reg_force);

`default_nettype wire

// File: sim/wbc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module wbc_host_model (
    input  wire logic i_mclk,
    input  wire logic i_miso,
    output logic      o_sclk,
    output logic      o_mosi,
    output logic      o_chip_select_n
);
    initial begin
        o_sclk = 1'b0;
        o_mosi = 1'b0;
        o_chip_select_n = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #2;
    endtask : tick

    // ==========================================
    // lsb-first frame of nb bits; counts other than 16 are sent as given
    // ==========================================
    task automatic xfer(input logic [15:0] tx, input int nb, output logic [15:0] rx);
        rx = 16'h0000;
        o_chip_select_n = 1'b0;
        tick(6);
        for (int i = 0; i < nb; i++) begin
            o_mosi = tx[i];
            tick(4);
            o_sclk = 1'b1;
            rx[i] = i_miso;
            tick(4);
            o_sclk = 1'b0;
        end
        tick(4);
        o_chip_select_n = 1'b1;
        // released line must not look held
        o_mosi = ~o_mosi;
        tick(8);
    endtask : xfer
endmodule : wbc_host_model

`default_nettype wire

// File: sim/wbc_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

module wbc_regs_tb;
    import wbc_pkg::*;
    logic       i_mclk, i_sys_rst, sclk, mosi, cs_n, miso, flash, sf;
    logic [2:0] mode;
    logic [3:0] ev;
    logic [5:0] cz;
    logic [7:0] d, prev;
    logic [15:0] rx;
    int         n_fail, checked, cyc, nsf;

    wbc_regs i_wbc_regs (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_sclk(sclk), .i_mosi(mosi),
        .i_chip_select_n(cs_n), .o_miso(miso), .o_miso_oe(), .i_status(8'h5A), .i_sbc_mode(mode),
        .i_soft_reset(ev[0]), .i_restart(ev[1]), .i_failsafe_entry(ev[2]), .i_trx_update(ev[3]),
        .i_cause_can_mode(cz[5:4]), .i_cause_lin_a_mode(cz[3:2]), .i_cause_lin_b_mode(cz[1:0]),
        .o_wdog_stop_disable_lo(), .o_wdog_window_select(), .o_wdog_start_on_bus_wake(),
        .o_wdog_period_sel(), .o_wdog_period_ms(), .o_wdog_checksum_ok(), .o_lin_flash_en(flash),
        .o_lin_low_slope_sel(), .o_lin_tx_timeout_en(), .o_lin_a_mode(), .o_lin_b_mode(), .o_can_mode(),
        .o_peak_current_thresh_sel(), .o_external_wake_reg_force(), .o_spi_fail(sf));
    wbc_host_model i_wbc_host_model (.i_mclk(i_mclk), .i_miso(miso), .o_sclk(sclk), .o_mosi(mosi),
        .o_chip_select_n(cs_n));

    initial begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end

    // ==========================================
    // access tasks
    // ==========================================
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [7:0] v, input logic [7:0] old);
        i_wbc_host_model.xfer({v, 1'b1, a}, 16, rx);
        chk(rx[15:8], old);
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        i_wbc_host_model.xfer({8'h00, 1'b0, a}, 16, rx);
        chk(rx[15:8], exp);
        chk(rx[7:0], 8'h5A);
    endtask : rd
    task automatic hw(input logic [3:0] e);
        @(posedge i_mclk);
        #2 ev = e;
        @(posedge i_mclk);
        #2 ev = 4'h0;
        repeat (3) @(posedge i_mclk);
        #2;
    endtask : hw
    task automatic wrap_up;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    // hang guard: about 130 frames of ~150 cycles each
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (sf) nsf <= nsf + 1;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    // ==========================================
    // main sequence
    // ==========================================
    initial begin
        i_sys_rst = 1'b1;
        ev = 4'h0;
        mode = WBC_SBC_NORMAL;
        cz = 6'h27;
        n_fail = 0;
        checked = 0;
        cyc = 0;
        nsf = 0;
        repeat (8) @(posedge i_mclk);
        #2 i_sys_rst = 1'b0;
        repeat (4) @(posedge i_mclk);
        #2;
        rd(WBC_ADDR_WDOG_CONFIG, 8'h14);
        rd(WBC_ADDR_BUS_CTRL_A, 8'h20);
        rd(WBC_ADDR_BUS_CTRL_B, 8'h00);
        rd(7'h7F, 8'h00);
        wr(WBC_ADDR_WDOG_CONFIG, 8'hEB, 8'h14);
        rd(WBC_ADDR_WDOG_CONFIG, 8'hE3);
        prev = 8'hE3;
        for (int p = 0; p < 6; p++) begin
            d = {^p[2:0], 4'h0, p[2:0]};
            wr(WBC_ADDR_WDOG_CONFIG, d, prev);
            prev = d;
        end
        wr(WBC_ADDR_WDOG_CONFIG, 8'h01, 8'h05);
        rd(WBC_ADDR_WDOG_CONFIG, 8'h05);
        wr(WBC_ADDR_WDOG_CONFIG, 8'h36, 8'h05);
        i_wbc_host_model.xfer({8'h00, 1'b1, WBC_ADDR_WDOG_CONFIG}, 12, rx);
        chk(nsf[7:0], 8'h02);
        rd(WBC_ADDR_WDOG_CONFIG, 8'h35);
        prev = 8'h20;
        for (int m = 0; m < 4; m++) begin
            d = {3'b110, m[1:0], 1'b1, m[1:0]};
            wr(WBC_ADDR_BUS_CTRL_A, d, prev);
            prev = d & 8'hFB;
            rd(WBC_ADDR_BUS_CTRL_A, prev);
        end
        chk({7'h00, flash}, 8'h01);
        wr(WBC_ADDR_BUS_CTRL_B, 8'hFF, 8'h00);
        rd(WBC_ADDR_BUS_CTRL_B, 8'h23);
        mode = WBC_SBC_STOP;
        wr(WBC_ADDR_BUS_CTRL_B, 8'h01, 8'h23);
        rd(WBC_ADDR_BUS_CTRL_B, 8'h21);
        mode = WBC_SBC_NORMAL;
        hw(4'h2);
        rd(WBC_ADDR_WDOG_CONFIG, 8'h34);
        rd(WBC_ADDR_BUS_CTRL_A, 8'hCA);
        rd(WBC_ADDR_BUS_CTRL_B, 8'h23);
        cz = 6'h38;
        hw(4'h8);
        rd(WBC_ADDR_BUS_CTRL_A, 8'hD3);
        rd(WBC_ADDR_BUS_CTRL_B, 8'h20);
        hw(4'h4);
        rd(WBC_ADDR_BUS_CTRL_A, 8'hC9);
        rd(WBC_ADDR_BUS_CTRL_B, 8'h01);
        hw(4'h1);
        rd(WBC_ADDR_WDOG_CONFIG, 8'h14);
        rd(WBC_ADDR_BUS_CTRL_A, 8'h20);
        rd(WBC_ADDR_BUS_CTRL_B, 8'h00);
        wrap_up();
    end
endmodule : wbc_regs_tb

`default_nettype wire
